// ==== rtl/brk_cmp_pkg.sv ====
// Shared constants, types and register map of the bus-cycle break comparator
package brk_cmp_pkg;

    localparam int NUM_SLOTS = 8;
    localparam int NUM_TYPES = 3;
    localparam int TOTAL_SLOTS = NUM_SLOTS * NUM_TYPES;
    localparam int DELAY_SLOT = 6;

    // Register map, byte addresses; slot block base + slot index * stride
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] SLOT_BASE = 12'h100;
    localparam logic [11:0] SLOT_STRIDE = 12'h020;
    localparam logic [2:0] SR_CFG = 3'h0;
    localparam logic [2:0] SR_ADDR_LO = 3'h1;
    localparam logic [2:0] SR_ADDR_HI = 3'h2;
    localparam logic [2:0] SR_AMASK = 3'h3;
    localparam logic [2:0] SR_DATA = 3'h4;
    localparam logic [2:0] SR_DMASK = 3'h5;
    localparam logic [2:0] SR_PINS = 3'h6;
    localparam logic [2:0] SR_COUNT = 3'h7;

    // Fields of the slot configuration word
    localparam int CF_EN = 0;
    localparam int CF_AEN = 1;
    localparam int CF_ARANGE = 2;
    localparam int CF_ANOT = 3;
    localparam int CF_DEN = 4;
    localparam int CF_DNOT = 5;
    localparam int CF_SIZE = 6;
    localparam int CF_LANE = 8;
    localparam int CF_DIREN = 11;
    localparam int CF_DIRW = 12;
    localparam int CF_CYC = 13;
    localparam int CF_PRBEN = 15;
    localparam int CF_NMIEN = 16;
    localparam int CF_NMIHI = 17;
    localparam int CF_IRQEN = 18;
    localparam int CF_CNTEN = 19;
    localparam int CF_DLYEN = 20;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    localparam logic [2:0] LANE_HW = 3'h0;
    localparam logic [2:0] LANE_LW = 3'h1;
    localparam logic [2:0] LANE_HH = 3'h2;
    localparam logic [2:0] LANE_HL = 3'h3;
    localparam logic [2:0] LANE_LH = 3'h4;
    localparam logic [2:0] LANE_LL = 3'h5;

    localparam logic [1:0] CYC_ANY = 2'h0;
    localparam logic [1:0] CYC_EXEC = 2'h1;
    localparam logic [1:0] CYC_DMA = 2'h2;

    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [14:0] DELAY_MAX = 15'h7fff;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    // One observed target bus cycle
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic write;
        logic [1:0] size;
        logic fetch;
        logic dma;
        logic [7:0] probe;
        logic nmi;
        logic [7:0] irq;
    } bus_cycle_s;

    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] addr_lo;
        logic [31:0] addr_hi;
        logic [31:0] amask;
        logic [31:0] data;
        logic [31:0] dmask;
        logic [31:0] pins;
        logic [31:0] count;
    } slot_cfg_s;

endpackage

// ==== rtl/bus_cycle_break_comparator.sv ====
// Hardware break comparator with AXI4-Lite slave for its slot registers
// Overview of operation
// [R01] Eight slots each for types A, B, C
// [R02] Satisfied condition raises the halt request
// [R03] Single address matches only equal address
// [R04] Address range match is inclusive both bounds
// [R05] Type B address inversion matches inequality
// [R06] Data match needs equal value and size
// [R07] Type B data inversion matches inequality
// [R08] Data never matches on instruction fetch
// [R09] Lane selector picks word or byte portion
// [R10] Types A, B qualify read or write
// [R11] Cycle type: execution, DMA or any
// [R12] Types A, B probe pattern with mask
// [R13] Types A, B NMI level, low default
// [R14] Types A, B IRQ pattern with mask
// [R15] Type B event count 1 to 65535
// [R16] Seventh B slot delay 1 to 32767
// [R17] Operator aligns longword address to four
// [R18] Word match without address needs four-alignment
// [R19] Byte match without address needs four-alignment
// [R20] All enabled qualifiers true same cycle
// [R21] Masked low address bits are ignored
// [R22] Halt may trail matching cycle by instructions
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module bus_cycle_break_comparator
    import brk_cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire bus_cycle_s bus_in,
    output logic break_req,
    output logic [TOTAL_SLOTS-1:0] slot_hit,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    slot_cfg_s cfg_q [TOTAL_SLOTS];
    logic [TOTAL_SLOTS-1:0] stored_q;
    logic [TOTAL_SLOTS-1:0] fire;
    logic [TOTAL_SLOTS-1:0] cond;
    logic [15:0] evt_cnt_q [TOTAL_SLOTS];
    logic [14:0] dly_cnt_q;
    logic dly_run_q;
    logic halted_q;
    logic brk_en_q;

    // ---------------- AXI4-Lite slave ----------------
    logic [31:0] awaddr_q;
    logic aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_have_q;
    logic wr_go;
    logic wr_ok;
    logic [4:0] wr_slot;
    logic [2:0] wr_reg;
    logic [31:0] wr_mask;
    logic clr_halt;

    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_slot = 5'((awaddr_q[11:0] - SLOT_BASE) >> 5);
    assign wr_reg = awaddr_q[4:2];
    assign wr_ok = (awaddr_q[11:0] >= SLOT_BASE)
        && (awaddr_q[11:0] < SLOT_BASE + 12'(TOTAL_SLOTS) * SLOT_STRIDE)
        && (awaddr_q[31:12] == 20'h00000);
    assign wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign clr_halt = wr_go && awaddr_q == {20'h00000, CTRL_OFS} && wstrb_q[0] && wdata_q[1];

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ok || awaddr_q == {20'h00000, CTRL_OFS}) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control word: bit 0 arms the comparator, bit 1 clears a pending halt
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            brk_en_q <= 1'b0;
        end else if (wr_go && awaddr_q == {20'h00000, CTRL_OFS} && wstrb_q[0]) begin
            brk_en_q <= wdata_q[0];
        end
    end

    logic [4:0] rd_slot;
    logic [31:0] rd_word;
    logic rd_ok;
    assign rd_slot = 5'((s_axi_araddr[11:0] - SLOT_BASE) >> 5);

    always_comb begin
        rd_ok = 1'b1;
        rd_word = 32'h0;
        if (s_axi_araddr == {20'h00000, CTRL_OFS}) begin
            rd_word = {31'h0, brk_en_q};
        end else if (s_axi_araddr == {20'h00000, STAT_OFS}) begin
            rd_word = {7'h0, stored_q, halted_q};
        end else if (s_axi_araddr[31:12] == 20'h00000 && s_axi_araddr[11:0] >= SLOT_BASE
                && s_axi_araddr[11:0] < SLOT_BASE + 12'(TOTAL_SLOTS) * SLOT_STRIDE) begin
            case (s_axi_araddr[4:2])
                SR_CFG: rd_word = cfg_q[rd_slot].cfg;
                SR_ADDR_LO: rd_word = cfg_q[rd_slot].addr_lo;
                SR_ADDR_HI: rd_word = cfg_q[rd_slot].addr_hi;
                SR_AMASK: rd_word = cfg_q[rd_slot].amask;
                SR_DATA: rd_word = cfg_q[rd_slot].data;
                SR_DMASK: rd_word = cfg_q[rd_slot].dmask;
                SR_PINS: rd_word = cfg_q[rd_slot].pins;
                default: rd_word = {16'h0, evt_cnt_q[rd_slot]};
            endcase
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------- Slots ----------------
    // Slot index s: type = s / 8, number = s % 8
    for (genvar s = 0; s < TOTAL_SLOTS; s++) begin : g_slot
        localparam bit IS_B = (s / NUM_SLOTS) == 1; // [R01]
        localparam bit HAS_PINS = (s / NUM_SLOTS) < 2;
        localparam bit HAS_DLY = IS_B && (s % NUM_SLOTS) == DELAY_SLOT;
        logic [31:0] c;
        logic a_eq;
        logic a_ok;
        logic d_ok;
        logic [31:0] lane_v;
        logic [31:0] lane_p;
        logic [31:0] lane_m;
        logic [1:0] want;
        logic q_ok;
        assign c = cfg_q[s].cfg;
        assign want = c[CF_SIZE +: 2];

        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                cfg_q[s] <= '{default: CFG_RST};
            end else if (wr_go && wr_ok && wr_slot == 5'(s)) begin
                case (wr_reg)
                    SR_CFG: cfg_q[s].cfg <= (cfg_q[s].cfg & ~wr_mask) | (wdata_q & wr_mask);
                    SR_ADDR_LO: cfg_q[s].addr_lo <= (cfg_q[s].addr_lo & ~wr_mask) | (wdata_q & wr_mask);
                    SR_ADDR_HI: cfg_q[s].addr_hi <= (cfg_q[s].addr_hi & ~wr_mask) | (wdata_q & wr_mask);
                    SR_AMASK: cfg_q[s].amask <= (cfg_q[s].amask & ~wr_mask) | (wdata_q & wr_mask);
                    SR_DATA: cfg_q[s].data <= (cfg_q[s].data & ~wr_mask) | (wdata_q & wr_mask);
                    SR_DMASK: cfg_q[s].dmask <= (cfg_q[s].dmask & ~wr_mask) | (wdata_q & wr_mask);
                    SR_PINS: cfg_q[s].pins <= (cfg_q[s].pins & ~wr_mask) | (wdata_q & wr_mask);
                    default: cfg_q[s].count <= (cfg_q[s].count & ~wr_mask) | (wdata_q & wr_mask);
                endcase
            end
        end

        // Mask register holds a run of low ones; forced contiguous so stray bits cannot leak
        logic [31:0] amask_c;
        always_comb begin
            amask_c = 32'h0;
            for (int i = 0; i < 32; i++) begin
                amask_c[i] = (i == 0) ? cfg_q[s].amask[0] : (amask_c[i-1] && cfg_q[s].amask[i]);
            end
        end

        always_comb begin
            a_eq = ((bus_in.addr ^ cfg_q[s].addr_lo) & ~amask_c) == 32'h0; // [R03] [R21]
            if (c[CF_ARANGE]) begin
                a_ok = bus_in.addr >= cfg_q[s].addr_lo && bus_in.addr <= cfg_q[s].addr_hi; // [R04]
            end else begin
                a_ok = a_eq;
            end
            if (IS_B && c[CF_ANOT] && !c[CF_ARANGE]) begin
                a_ok = !a_eq; // [R05]
            end
        end

        always_comb begin
            case (c[CF_LANE +: 3]) // [R09]
                LANE_HW: begin
                    lane_v = {16'h0, bus_in.data[31:16]};
                    lane_p = {16'h0, cfg_q[s].data[15:0]};
                    lane_m = {16'h0, cfg_q[s].dmask[15:0]};
                end
                LANE_LW: begin
                    lane_v = {16'h0, bus_in.data[15:0]};
                    lane_p = {16'h0, cfg_q[s].data[15:0]};
                    lane_m = {16'h0, cfg_q[s].dmask[15:0]};
                end
                LANE_HH, LANE_HL, LANE_LH, LANE_LL: begin
                    lane_v = {24'h0, bus_in.data[8*(5-c[CF_LANE +: 3]) +: 8]};
                    lane_p = {24'h0, cfg_q[s].data[7:0]};
                    lane_m = {24'h0, cfg_q[s].dmask[7:0]};
                end
                default: begin
                    lane_v = bus_in.data;
                    lane_p = cfg_q[s].data;
                    lane_m = cfg_q[s].dmask;
                end
            endcase
        end

        logic d_eq;
        logic d_align;
        assign d_eq = ((lane_v ^ lane_p) & ~lane_m) == 32'h0;
        // Without an address qualifier (or masked) word/byte hits only at four-aligned
        assign d_align = (c[CF_AEN] && amask_c == 32'h0) || bus_in.addr[1:0] == 2'h0; // [R18] [R19]

        always_comb begin
            d_ok = (IS_B && c[CF_DNOT]) ? !d_eq : d_eq; // [R06] [R07]
            d_ok = d_ok && bus_in.size == want && !bus_in.fetch && d_align; // [R06] [R08]
        end

        always_comb begin
            q_ok = bus_in.valid && c[CF_EN]; // [R20]
            if (c[CF_AEN] && !a_ok) q_ok = 1'b0;
            if (c[CF_DEN] && !d_ok) q_ok = 1'b0;
            if (HAS_PINS && c[CF_DIREN] && bus_in.write != c[CF_DIRW]) q_ok = 1'b0; // [R10]
            case (c[CF_CYC +: 2]) // [R11]
                CYC_EXEC: if (bus_in.fetch || bus_in.dma) q_ok = 1'b0;
                CYC_DMA: if (!bus_in.dma) q_ok = 1'b0;
                default: ;
            endcase
            if (HAS_PINS && c[CF_PRBEN] && (((bus_in.probe ^ cfg_q[s].pins[7:0])
                    & ~cfg_q[s].pins[15:8]) != 8'h0)) q_ok = 1'b0; // [R12]
            if (HAS_PINS && c[CF_NMIEN] && bus_in.nmi != c[CF_NMIHI]) q_ok = 1'b0; // [R13]
            if (HAS_PINS && c[CF_IRQEN] && (((bus_in.irq ^ cfg_q[s].pins[23:16])
                    & ~cfg_q[s].pins[31:24]) != 8'h0)) q_ok = 1'b0; // [R14]
        end
        assign cond[s] = q_ok;

        // Event counter counts occurrences; zero programmed count behaves as one
        always_ff @(posedge ref_clk) begin
            if (sys_rst || clr_halt) begin
                evt_cnt_q[s] <= 16'h0;
            end else if (IS_B && c[CF_CNTEN] && q_ok && brk_en_q && evt_cnt_q[s] != COUNT_MAX) begin
                evt_cnt_q[s] <= evt_cnt_q[s] + 16'h1; // [R15]
            end
        end

        logic cnt_done;
        assign cnt_done = !(IS_B && c[CF_CNTEN])
            || (evt_cnt_q[s] + 16'h1 >= cfg_q[s].count[15:0]); // [R15]
        if (HAS_DLY) begin : g_dly
            assign fire[s] = q_ok && cnt_done && !c[CF_DLYEN];
        end else begin : g_nodly
            assign fire[s] = q_ok && cnt_done;
        end
    end

    // Delay: counts valid bus cycles after the delay slot condition
    logic dly_start;
    logic [14:0] dly_target;
    assign dly_start = cond[NUM_SLOTS + DELAY_SLOT] && cfg_q[NUM_SLOTS + DELAY_SLOT].cfg[CF_DLYEN]
        && g_slot[NUM_SLOTS + DELAY_SLOT].cnt_done && brk_en_q && !dly_run_q && !halted_q;
    assign dly_target = cfg_q[NUM_SLOTS + DELAY_SLOT].count[30:16];

    always_ff @(posedge ref_clk) begin
        if (sys_rst || clr_halt) begin
            dly_run_q <= 1'b0;
            dly_cnt_q <= 15'h0;
        end else if (dly_start) begin
            dly_run_q <= 1'b1; // [R16]
            dly_cnt_q <= 15'h0;
        end else if (dly_run_q && bus_in.valid) begin
            dly_cnt_q <= dly_cnt_q + 15'h1;
            if (dly_cnt_q + 15'h1 >= dly_target) dly_run_q <= 1'b0;
        end
    end

    logic dly_fire;
    assign dly_fire = dly_run_q && bus_in.valid && (dly_cnt_q + 15'h1 >= dly_target); // [R16]

    // Halt request holds until software clears it; the core may stop some instructions late
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            halted_q <= 1'b0;
            break_req <= 1'b0;
            stored_q <= '0;
            slot_hit <= '0;
        end else if (brk_en_q && ((|fire) || dly_fire)) begin
            halted_q <= 1'b1; // [R02] [R22]
            break_req <= 1'b1;
            stored_q <= stored_q | fire;
            slot_hit <= slot_hit | fire;
        end else if (clr_halt) begin
            halted_q <= 1'b0;
            break_req <= 1'b0;
            stored_q <= '0;
            slot_hit <= '0;
        end
    end

    fire_halts_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (brk_en_q && |fire) |=> break_req) else $error("hit did not raise break"); // [R02]
    fetch_no_data_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_in.fetch && cfg_q[2].cfg[CF_DEN] && cfg_q[2].cfg[CF_EN]) |-> !cond[2])
        else $error("data match on fetch"); // [R08]
    held_break_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (break_req && !clr_halt) |=> break_req) else $error("break dropped"); // [R02]
    c_no_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $stable(cfg_q[16]) && cfg_q[16].cfg[CF_EN] && !cfg_q[16].cfg[CF_DEN]
        && !cfg_q[16].cfg[CF_AEN] && cfg_q[16].cfg[CF_CYC +: 2] == CYC_ANY && bus_in.valid
        |-> cond[16]) else $error("type C qualifier leaked"); // [R10]
    dly_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        dly_start && dly_target > 15'h1 |=> !dly_fire) else $error("delay too short"); // [R16]
    dma_sel_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cfg_q[3].cfg[CF_CYC +: 2] == CYC_DMA && !bus_in.dma |-> !cond[3])
        else $error("dma qualifier failed"); // [R11]
    range_in_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cond[23] && cfg_q[23].cfg[CF_AEN] && cfg_q[23].cfg[CF_ARANGE]
        |-> bus_in.addr >= cfg_q[23].addr_lo && bus_in.addr <= cfg_q[23].addr_hi)
        else $error("range match outside bounds"); // [R04]
    size_match_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cond[2] && cfg_q[2].cfg[CF_DEN] |-> bus_in.size == cfg_q[2].cfg[CF_SIZE +: 2])
        else $error("data size mismatch"); // [R06]

endmodule

// ==== tb/target_bus_model.sv ====
// Behavioural model of the target processor bus that presents observed cycles
`timescale 1ns/1ps
module target_bus_model
    import brk_cmp_pkg::*;
(
    input wire logic ref_clk,
    output bus_cycle_s bus_out
);
    initial begin
        bus_out = '0;
    end

    // Idle bus shows the inverse of the last cycle, so a stale pattern never matches by luck
    task automatic cyc(input bus_cycle_s c);
        bus_cycle_s n;
        c.valid = 1'b1;
        if (c.size == SIZE_LONG) c.addr[1:0] = 2'h0;
        bus_out <= c;
        @(posedge ref_clk);
        n = ~c;
        n.valid = 1'b0;
        bus_out <= n;
        @(posedge ref_clk);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench for the bus-cycle break comparator
`timescale 1ns/1ps
module tb_top;
    import brk_cmp_pkg::*;
    logic ref_clk;
    logic sys_rst;
    bus_cycle_s bus_in;
    logic break_req;
    logic [TOTAL_SLOTS-1:0] slot_hit;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int err_count;
    int comparisons;

    bus_cycle_break_comparator i_bus_cycle_break_comparator (.ref_clk, .sys_rst, .bus_in,
        .break_req, .slot_hit, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    target_bus_model i_target_bus_model (.ref_clk, .bus_out(bus_in));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Address and data go out together; each is dropped on its own acceptance edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        logic aw = 1'b0;
        logic w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw && w));
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    function automatic logic [31:0] sa(input int s, input logic [2:0] r);
        return 32'(SLOT_BASE) + 32'(s) * 32'(SLOT_STRIDE) + 32'(r) * 32'h4;
    endfunction

    function automatic logic [31:0] b(input int i);
        return 32'h1 << i;
    endfunction

    function automatic bus_cycle_s mk(input logic [31:0] a, input logic [31:0] d = '0,
        input logic [1:0] sz = SIZE_LONG);
        bus_cycle_s c;
        c = '0;
        c.addr = a;
        c.data = d;
        c.size = sz;
        return c;
    endfunction

    task automatic setup(input int s, input logic [31:0] cfg, input logic [31:0] lo,
        input logic [31:0] hi = '0, input logic [31:0] d = '0, input logic [31:0] p = '0);
        axi_wr(sa(s, SR_ADDR_LO), lo);
        axi_wr(sa(s, SR_ADDR_HI), hi);
        axi_wr(sa(s, SR_AMASK), '0);
        axi_wr(sa(s, SR_DATA), d);
        axi_wr(sa(s, SR_DMASK), '0);
        axi_wr(sa(s, SR_PINS), p);
        axi_wr(sa(s, SR_COUNT), '0);
        axi_wr(sa(s, SR_CFG), cfg | b(CF_EN));
    endtask

    task automatic look(input int s, input logic e);
        repeat (2) @(posedge ref_clk);
        chk("break_req", 32'(break_req), 32'(e));
        if (e) chk("slot_hit", 32'(slot_hit[s]), 32'h1);
    endtask

    // Clearing keeps the comparator armed and resets its counters
    task automatic tryc(input int s, input bus_cycle_s c, input logic e);
        i_target_bus_model.cyc(c);
        look(s, e);
        axi_wr(32'(CTRL_OFS), 32'h3);
    endtask

    task automatic sc_addr;
        logic [31:0] ad[4] = '{32'h1ffc, 32'h2000, 32'h2010, 32'h2014};
        setup(0, b(CF_AEN), 32'h1000);
        tryc(0, mk(32'h1000), 1'b1);
        tryc(0, mk(32'h1004), 1'b0);
        axi_wr(sa(0, SR_AMASK), 32'hf);
        tryc(0, mk(32'h100c), 1'b1);
        tryc(0, mk(32'h1010), 1'b0);
        axi_wr(sa(0, SR_CFG), CFG_RST);
        setup(23, b(CF_AEN) | b(CF_ARANGE), 32'h2000, 32'h2010);
        for (int i = 0; i < 4; i++) tryc(23, mk(ad[i]), i == 1 || i == 2);
        axi_wr(sa(23, SR_CFG), CFG_RST);
    endtask

    task automatic sc_not;
        setup(8, b(CF_AEN) | b(CF_ANOT), 32'h3000);
        tryc(8, mk(32'h3000), 1'b0);
        tryc(8, mk(32'h3004), 1'b1);
        setup(8, b(CF_DEN) | b(CF_DNOT) | (LANE_LL << CF_LANE), '0, '0, 32'h11);
        tryc(8, mk('0, 32'h22, SIZE_BYTE), 1'b1);
        tryc(8, mk('0, 32'h11, SIZE_BYTE), 1'b0);
        axi_wr(sa(8, SR_CFG), CFG_RST);
        setup(1, b(CF_AEN) | b(CF_ANOT), 32'h3000);
        tryc(1, mk(32'h3004), 1'b0);
        axi_wr(sa(1, SR_CFG), CFG_RST);
    endtask

    task automatic sc_data;
        int sh[6] = '{16, 0, 24, 16, 8, 0};
        bus_cycle_s c;
        setup(2, b(CF_DEN) | (SIZE_WORD << CF_SIZE), '0, '0, 32'h1234);
        c = mk('0, 32'h1234_0000, SIZE_WORD);
        tryc(2, c, 1'b1);
        tryc(2, mk('0, 32'h1234_0000, SIZE_BYTE), 1'b0);
        tryc(2, mk(32'h2, 32'h1234_0000, SIZE_WORD), 1'b0);
        c.fetch = 1'b1;
        tryc(2, c, 1'b0);
        for (int i = 0; i < 6; i++) begin
            setup(2, b(CF_DEN) | ((i < 2 ? SIZE_WORD : SIZE_BYTE) << CF_SIZE)
                | (32'(i) << CF_LANE), '0, '0, 32'ha5);
            tryc(2, mk('0, 32'ha5 << sh[i], i < 2 ? SIZE_WORD : SIZE_BYTE), 1'b1);
        end
        tryc(2, mk(32'h5, 32'ha5, SIZE_BYTE), 1'b0);
        axi_wr(sa(2, SR_CFG), CFG_RST);
    endtask

    task automatic sc_qual;
        bus_cycle_s c;
        c = mk(32'h40);
        setup(3, b(CF_DIREN) | b(CF_DIRW), '0);
        tryc(3, c, 1'b0);
        c.write = 1'b1;
        tryc(3, c, 1'b1);
        setup(3, CYC_EXEC << CF_CYC, '0);
        tryc(3, c, 1'b1);
        c.dma = 1'b1;
        tryc(3, c, 1'b0);
        setup(3, CYC_DMA << CF_CYC, '0);
        tryc(3, c, 1'b1);
        setup(3, CYC_ANY << CF_CYC, '0);
        c.fetch = 1'b1;
        tryc(3, c, 1'b1);
        axi_wr(sa(3, SR_CFG), CFG_RST);
        setup(16, b(CF_DIREN) | b(CF_DIRW), '0);
        tryc(16, mk(32'h40), 1'b1);
        axi_wr(sa(16, SR_CFG), CFG_RST);
    endtask

    task automatic sc_pins;
        bus_cycle_s c;
        c = mk(32'h80);
        setup(4, b(CF_NMIEN), '0);
        tryc(4, c, 1'b1);
        axi_wr(sa(4, SR_CFG), CFG_RST);
        setup(10, b(CF_PRBEN) | b(CF_NMIEN) | b(CF_NMIHI) | b(CF_IRQEN), '0, '0, '0,
            32'h0081_0f5a);
        c.probe = 8'h53;
        c.irq = 8'h81;
        tryc(10, c, 1'b0);
        c.nmi = 1'b1;
        tryc(10, c, 1'b1);
        c.irq = 8'h80;
        tryc(10, c, 1'b0);
        c.irq = 8'h81;
        c.probe = 8'h43;
        tryc(10, c, 1'b0);
        axi_wr(sa(10, SR_CFG), CFG_RST);
    endtask

    task automatic sc_counts;
        setup(11, b(CF_AEN) | b(CF_CNTEN), 32'h5000);
        axi_wr(sa(11, SR_COUNT), 32'h3);
        repeat (2) i_target_bus_model.cyc(mk(32'h5000));
        look(11, 1'b0);
        tryc(11, mk(32'h5000), 1'b1);
        axi_wr(sa(11, SR_CFG), CFG_RST);
        setup(14, b(CF_AEN) | b(CF_DLYEN), 32'h6000);
        axi_wr(sa(14, SR_COUNT), 32'h0002_0000);
        i_target_bus_model.cyc(mk(32'h6000));
        i_target_bus_model.cyc(mk(32'h7000));
        look(14, 1'b0);
        i_target_bus_model.cyc(mk(32'h7000));
        repeat (2) @(posedge ref_clk);
        chk("delay_break", 32'(break_req), 32'h1);
        axi_wr(32'(CTRL_OFS), 32'h3);
        axi_wr(sa(14, SR_CFG), CFG_RST);
    endtask

    task automatic sc_bus;
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(sa(5, SR_CFG), d, r);
        chk("cfg_reset", d, CFG_RST);
        axi_rd(32'hff0, d, r);
        chk("rresp_unmapped", 32'(r), 32'h2);
        axi_wr(32'hff0, '0);
        chk("bresp", 32'(s_axi_bresp), 32'h2);
        axi_wr(32'(CTRL_OFS), '0);
        setup(0, b(CF_AEN), 32'h1000);
        i_target_bus_model.cyc(mk(32'h1000));
        look(0, 1'b0);
        axi_wr(32'(CTRL_OFS), 32'h1);
        i_target_bus_model.cyc(mk(32'h1000));
        look(0, 1'b1);
        axi_rd(32'(STAT_OFS), d, r);
        chk("stat_halted", 32'(d[0]), 32'h1);
        axi_wr(32'(CTRL_OFS), 32'h3);
        axi_rd(32'(STAT_OFS), d, r);
        chk("stat_cleared", 32'(d[0]), 32'h0);
    endtask

    initial begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        axi_wr(32'(CTRL_OFS), 32'h1);
        sc_addr();
        sc_not();
        sc_data();
        sc_qual();
        sc_pins();
        sc_counts();
        sc_bus();
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end
endmodule
